/* bench/ppc_chk.sv */
// Checker: port-level properties of the port pin control block
`default_nettype none
module ppc_chk (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [7:0]  pt_pin_i,
    input wire logic [7:0]  pt_capture_o,
    input wire logic [7:0]  pt_compare_en_i,
    input wire logic [7:0]  pt_pin_oe_o,
    input wire logic [3:0]  ps_drive_reduce_o,
    input wire logic [3:0]  ps_pin_oe_o,
    input wire logic [7:0]  pk_pullup_on_o,
    input wire logic [7:0]  pk_pin_oe_o,
    input wire logic        pk_ext_echo_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    a_ready_wait: assert property (psel_i && penable_i && !$past(penable_i) |=> pready_o)
        else $error("pready missing after access edge");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready_o |-> $past(psel_i) && $past(penable_i))
        else $error("pready without access");
    a_err_zero: assert property (pslverr_o |-> prdata_o == 32'h0)
        else $error("error response with data");
    a_echo_err: assert property (pk_ext_echo_o |-> pready_o && pslverr_o)
        else $error("echo without error response");
    a_capture_pin: assert property ($stable(pt_pin_i)[*4] |-> pt_capture_o == pt_pin_i)
        else $error("capture differs from pin");
    a_compare_oe: assert property (1'b1 |=>
        (pt_pin_oe_o & $past(pt_compare_en_i)) == $past(pt_compare_en_i))
        else $error("compare did not force output");
    a_drive_inputs: assert property ((ps_drive_reduce_o & ~ps_pin_oe_o) == 4'h0)
        else $error("reduced drive on input");
    a_pullup_inputs: assert property ((pk_pullup_on_o & pk_pin_oe_o) == 8'h00)
        else $error("pull-up on driven pin");
    c_echo: cover property (pk_ext_echo_o);
    c_error: cover property (pslverr_o);
    c_compare: cover property (pt_compare_en_i != 8'h00);
endmodule
bind ppc_top ppc_chk ppc_chk_inst (
    .clk_sys_i         (clk_sys_i),
    .reset_i           (reset_i),
    .psel_i            (psel_i),
    .penable_i         (penable_i),
    .prdata_o          (prdata_o),
    .pready_o          (pready_o),
    .pslverr_o         (pslverr_o),
    .pt_pin_i          (pt_pin_i),
    .pt_capture_o      (pt_capture_o),
    .pt_compare_en_i   (pt_compare_en_i),
    .pt_pin_oe_o       (pt_pin_oe_o),
    .ps_drive_reduce_o (ps_drive_reduce_o),
    .ps_pin_oe_o       (ps_pin_oe_o),
    .pk_pullup_on_o    (pk_pullup_on_o),
    .pk_pin_oe_o       (pk_pin_oe_o),
    .pk_ext_echo_o     (pk_ext_echo_o)
);
`default_nettype wire

/* bench/ppc_pins.sv */
// Pin model: resolves each pad from block drive, far-side drive and pull
`default_nettype none
module ppc_pins #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] o_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pull_i,
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] ext_i,
    output logic      [W-1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] last_q;
    // Floating pad keeps no level: it flips every cycle
    always_comb begin
        for (int b = 0; b < W; b++) begin
            pin_o[b] = oe_i[b] ? o_i[b] : drv_i[b] ? ext_i[b] : pull_i[b] ? 1'b1 : ~last_q[b];
        end
    end
    always_ff @(posedge clk_i) begin
        last_q <= pin_o;
    end
endmodule
`default_nettype wire

/* bench/ppc_top_bench.sv */
// Testbench: register and pin tests of the port pin control block
`default_nettype none
module ppc_top_bench import ppc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, pk_ext_echo_o;
    logic [7:0]  pt_pin_i, pt_pin_o, pt_pin_oe_o, pt_capture_o;
    logic [7:0]  pt_compare_en_i = 8'h00;
    logic [7:0]  pt_compare_val_i = 8'h00;
    logic [3:0]  ps_pin_i, ps_pin_o, ps_pin_oe_o, ps_drive_reduce_o, ps_pull_on_o;
    logic [7:0]  pk_pin_i, pk_pin_o, pk_pin_oe_o, pk_pullup_on_o;
    logic        ext_bus_clk_i = 1'b1;
    logic        ext_emu_access_i = 1'b0;
    logic        ext_ext_access_i = 1'b0;
    logic        ext_stretch_i = 1'b0;
    logic [5:0]  ext_page_i = 6'h00;
    logic [7:0]  t_ext = 8'h00;
    logic [7:0]  k_ext = 8'h00;
    logic [3:0]  s_drv = 4'h0;
    logic [3:0]  s_ext = 4'h0;
    logic [7:0]  rd;
    logic        er, echo, seen;
    int          fail_count = 0;
    int          n_compared = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    ppc_top ppc_top_inst (.*);
    ppc_pins #(.W(8)) pt_pins (.clk_i(clk_sys_i), .o_i(pt_pin_o), .oe_i(pt_pin_oe_o),
        .pull_i(8'h00), .drv_i(8'hff), .ext_i(t_ext), .pin_o(pt_pin_i));
    ppc_pins #(.W(4)) ps_pins (.clk_i(clk_sys_i), .o_i(ps_pin_o), .oe_i(ps_pin_oe_o),
        .pull_i(ps_pull_on_o), .drv_i(s_drv), .ext_i(s_ext), .pin_o(ps_pin_i));
    ppc_pins #(.W(8)) pk_pins (.clk_i(clk_sys_i), .o_i(pk_pin_o), .oe_i(pk_pin_oe_o),
        .pull_i(pk_pullup_on_o), .drv_i(8'hff), .ext_i(k_ext), .pin_o(pk_pin_i));

    task automatic finish_test;
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= {24'h0, wd};
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o[7:0];
        er = pslverr_o;
        echo = pk_ext_echo_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            fail_count++;
            finish_test;
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        cmp(rd, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        finish_test;
    end

    initial begin
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        tick(1);
        cmp({4'h0, ps_pull_on_o}, 8'h0f);
        cmp(pk_pullup_on_o, 8'hff);
        rdc(PS_PULL_EN_IDX, RST_PS_PULL);
        rdc(PULLUP_CTRL_IDX, RST_PULLUP_CONTROL_REG);
        rdc(PT_DIRECTION_IDX, RST_ZERO);
        rdc(PS_DRIVE_RED_IDX, RST_ZERO);
        t_ext <= 8'h3c;
        wr(PT_DATA_IDX, 8'ha5);
        wr(PT_DIRECTION_IDX, 8'hff);
        tick(4);
        cmp(pt_pin_oe_o, 8'hff);
        cmp(pt_pin_o, 8'ha5);
        rdc(PT_PIN_INPUT_IDX, 8'ha5);
        wr(PT_DIRECTION_IDX, 8'h0f);
        tick(3);
        rdc(PT_PIN_INPUT_IDX, 8'h35);
        cmp(pt_capture_o, 8'h35);
        wr(PT_PIN_INPUT_IDX, 8'h00);
        cmp({7'h0, er}, 8'h00);
        rdc(PT_PIN_INPUT_IDX, 8'h35);
        pt_compare_val_i <= 8'h80;
        pt_compare_en_i <= 8'h80;
        tick(5);
        cmp(pt_pin_oe_o, 8'h8f);
        cmp(pt_capture_o, 8'hb5);
        rdc(PT_DIRECTION_IDX, 8'h0f);
        pt_compare_en_i <= 8'h00;
        tick(2);
        cmp(pt_pin_oe_o, 8'h0f);
        wr(PS_DIRECTION_IDX, 8'h03);
        wr(PS_DRIVE_RED_IDX, 8'h0f);
        tick(2);
        cmp({4'h0, ps_drive_reduce_o}, 8'h03);
        cmp({4'h0, ps_pull_on_o}, 8'h0c);
        wr(PS_OPEN_DRAIN_IDX, 8'h01);
        tick(2);
        cmp({4'h0, ps_pull_on_o}, 8'h0d);
        s_drv <= 4'hc;
        s_ext <= 4'h4;
        wr(PS_DATA_IDX, 8'h03);
        tick(4);
        cmp({4'h0, ps_pin_o}, 8'h02);
        cmp({4'h0, ps_pin_oe_o}, 8'h02);
        cmp({4'h0, ps_drive_reduce_o}, 8'h02);
        rdc(PS_DATA_IDX, 8'h07);
        wr(PS_PULL_EN_IDX, 8'h00);
        tick(2);
        cmp({4'h0, ps_pull_on_o}, 8'h00);
        k_ext <= 8'h33;
        wr(PK_DIRECTION_IDX, 8'hf0);
        wr(PK_DATA_IDX, 8'h5a);
        tick(4);
        cmp(pk_pin_oe_o, 8'hf0);
        cmp(pk_pullup_on_o, 8'h0f);
        rdc(PK_DATA_IDX, 8'h53);
        wr(PULLUP_CTRL_IDX, 8'h00);
        tick(2);
        cmp(pk_pullup_on_o, 8'h00);
        ext_page_i <= 6'h2a;
        ext_emu_access_i <= 1'b1;
        wr(MODE_CTRL_IDX, 8'h01);
        tick(6);
        cmp({2'b00, pk_pin_o[5:0]}, 8'h2a);
        cmp({7'h0, pk_pin_o[7]}, 8'h00);
        cmp(pk_pin_oe_o, 8'hff);
        ext_emu_access_i <= 1'b0;
        ext_ext_access_i <= 1'b1;
        tick(6);
        cmp({6'h0, pk_pin_o[7:6]}, 8'h02);
        for (int s = 0; s < 2; s++) begin
            ext_stretch_i <= s[0];
            tick(4);
            ext_bus_clk_i <= 1'b0;
            seen = 1'b0;
            repeat (8) begin
                @(posedge clk_sys_i);
                if (pk_pin_o[6] === 1'b1) seen = 1'b1;
            end
            ext_bus_clk_i <= 1'b1;
            cmp({7'h0, seen}, {7'h0, ~s[0]});
        end
        wr(MODE_CTRL_IDX, 8'h03);
        xfer(1'b0, PK_DATA_IDX, 8'h00);
        cmp({6'h0, er, echo}, 8'h03);
        xfer(1'b0, 8'h3f, 8'h00);
        cmp({7'h0, er}, 8'h01);
        finish_test;
    end
endmodule
`default_nettype wire

/* hw/ppc_pkg.sv */
// Package: register map, field layout and reset values of the port pin control block
`default_nettype none
package ppc_pkg;
    localparam logic [7:0] PT_PIN_INPUT_IDX  = 8'h01;
    localparam logic [7:0] PT_DIRECTION_IDX  = 8'h02;
    localparam logic [7:0] PT_DATA_IDX       = 8'h00;
    localparam logic [7:0] PS_DRIVE_RED_IDX  = 8'h0b;
    localparam logic [7:0] PS_PULL_EN_IDX    = 8'h0c;
    localparam logic [7:0] PS_DATA_IDX       = 8'h0d;
    localparam logic [7:0] PS_DIRECTION_IDX  = 8'h0e;
    localparam logic [7:0] PS_OPEN_DRAIN_IDX = 8'h0f;
    localparam logic [7:0] PULLUP_CTRL_IDX   = 8'h10;
    localparam logic [7:0] MODE_CTRL_IDX     = 8'h11;
    localparam logic [7:0] PK_DATA_IDX       = 8'h32;
    localparam logic [7:0] PK_DIRECTION_IDX  = 8'h33;
    localparam logic [7:0] PK_PAGE_IDX       = 8'h34;

    localparam int PS_WIDTH         = 4;
    localparam int PK_CS_EMU_BIT    = 7;
    localparam int PK_CS_EXT_BIT    = 6;
    localparam int PK_PAGE_MSB      = 5;
    localparam int PULLUP_CONTROL_REG_PK_PULL_BIT = 7;
    localparam int MODE_EMK_BIT     = 0;
    localparam int MODE_EXP_BIT     = 1;
    localparam int MODE_STR_BIT     = 2;

    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_PS_PULL  = 8'h0f;
    localparam logic [7:0] RST_PULLUP_CONTROL_REG     = 8'h80;

    // Quarter of one external bus clock phase, in system clock cycles
    localparam int          CS_GAP_NS     = 1;
    localparam int          CLK_PERIOD_NS = 4;
    localparam logic [1:0]  CS_GAP_CYC    = 2'((CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage
`default_nettype wire

/* hw/ppc_sync.sv */
// Two flip-flop synchroniser for eight pin inputs
`default_nettype none
module ppc_sync (
    input  wire logic  clk_sys_i,
    input  wire logic  reset_i,
    ppc_sync_if.dst    sif
);
    logic [7:0] meta_q;
    logic [7:0] meta_d;
    logic [7:0] sync_q;
    logic [7:0] sync_d;

    always_comb begin
        meta_d = sif.raw;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sif.synced = sync_q;
endmodule
`default_nettype wire

/* hw/ppc_sync_if.sv */
// Interface: raw pin levels in and synchronised levels out
`default_nettype none
interface ppc_sync_if;
    logic [7:0] raw;
    logic [7:0] synced;
    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface
`default_nettype wire

/* hw/ppc_top.sv */
// Port pin control: port T, port S and paged port with APB register access
// Overview of operation
// - Port T pin-input reads give the present pin levels; writes are ignored.
// - Port T direction bit set makes output, cleared makes input.
// - Enabled output compare forces pin to output; stored direction unchanged.
// - Disabled output compare returns control to the direction bit.
// - Capture path always sees the port T pin level.
// - Reads may lag direction changes by up to three cycles.
// - Port S reduced-drive bit selects reduced drive; ignored for inputs.
// - Port S pull-enable bit enables pull for inputs or open drain; on at reset.
// - Port S pull-enable has no effect on push-pull outputs.
// - Paged port direction 1 is output, 0 is high-impedance input.
// - Paged port reads return pin for inputs, stored data for outputs.
// - With emulation in expanded modes, paged port register leaves the map.
// - Paged port inputs pulled up per one port-wide pull-up bit.
// - Emulation makes bit 7 the emulated memory chip select.
// - Emulation makes bit 6 the external chip select.
// - Chip selects are held high for a quarter cycle after bus clock fall unless stretched.
// - Emulation drives bits 5 to 0 with the expanded page address.
//
// The APB interface to the registers was left to the implementer.
`default_nettype none
module ppc_top
    import ppc_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [7:0]  pt_pin_i,
    output logic      [7:0]  pt_pin_o,
    output logic      [7:0]  pt_pin_oe_o,
    input  wire logic [7:0]  pt_compare_en_i,
    input  wire logic [7:0]  pt_compare_val_i,
    output logic      [7:0]  pt_capture_o,
    input  wire logic [3:0]  ps_pin_i,
    output logic      [3:0]  ps_pin_o,
    output logic      [3:0]  ps_pin_oe_o,
    output logic      [3:0]  ps_drive_reduce_o,
    output logic      [3:0]  ps_pull_on_o,
    input  wire logic [7:0]  pk_pin_i,
    output logic      [7:0]  pk_pin_o,
    output logic      [7:0]  pk_pin_oe_o,
    output logic      [7:0]  pk_pullup_on_o,
    input  wire logic        ext_bus_clk_i,
    input  wire logic        ext_emu_access_i,
    input  wire logic        ext_ext_access_i,
    input  wire logic        ext_stretch_i,
    input  wire logic [5:0]  ext_page_i,
    output logic             pk_ext_echo_o
);
    import ppc_pkg::*;

    // Input synchronisers
    ppc_sync_if pt_sif ();
    ppc_sync_if ps_sif ();
    ppc_sync_if pk_sif ();
    ppc_sync_if ctl_sif ();
    assign pt_sif.raw  = pt_pin_i;
    assign ps_sif.raw  = {4'h0, ps_pin_i};
    assign pk_sif.raw  = pk_pin_i;
    assign ctl_sif.raw = {4'h0, ext_stretch_i, ext_ext_access_i, ext_emu_access_i,
                          ext_bus_clk_i};
    ppc_sync u_pt_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .sif       (pt_sif)
    );

    ppc_sync u_ps_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .sif       (ps_sif)
    );

    ppc_sync u_pk_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .sif       (pk_sif)
    );

    ppc_sync u_ctl_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .sif       (ctl_sif)
    );

    logic [7:0] pt_level;
    logic [3:0] ps_level;
    logic [7:0] pk_level;
    logic       external_bus_clock_s;
    logic       emu_acc_s;
    logic       ext_acc_s;
    logic       stretch_s;
    assign pt_level  = pt_sif.synced;
    assign ps_level  = ps_sif.synced[3:0];
    assign pk_level  = pk_sif.synced;
    assign external_bus_clock_s    = ctl_sif.synced[0];
    assign emu_acc_s = ctl_sif.synced[1];
    assign ext_acc_s = ctl_sif.synced[2];
    assign stretch_s = ctl_sif.synced[3];

    // Register state
    logic [7:0] pt_data_q,  pt_data_d;
    logic [7:0] pt_dir_q,   pt_dir_d;
    logic [7:0] ps_drv_q,   ps_drv_d;
    logic [7:0] ps_pull_q,  ps_pull_d;
    logic [7:0] ps_data_q,  ps_data_d;
    logic [7:0] ps_dir_q,   ps_dir_d;
    logic [7:0] ps_od_q,    ps_od_d;
    logic [7:0] pullup_control_reg_q,     pullup_control_reg_d;
    logic [7:0] mode_q,     mode_d;
    logic [7:0] pk_data_q,  pk_data_d;
    logic [7:0] pk_dir_q,   pk_dir_d;
    logic [31:0] prdata_q,  prdata_d;
    logic        pready_q,  pready_d;
    logic        pslverr_q, pslverr_d;
    logic        echo_q,    echo_d;

    logic       emulate_expansion_enable;
    logic       pk_unmapped;
    logic       acc_setup;
    logic       wr_en;
    logic [9:0] idx;
    logic       aligned;
    logic       hit;
    logic [7:0] rd_byte;
    logic [7:0] pt_dir_eff;

    assign emulate_expansion_enable         = mode_q[MODE_EMK_BIT];
    assign pk_unmapped = emulate_expansion_enable && mode_q[MODE_EXP_BIT];
    assign idx         = paddr_i[11:2];
    assign aligned     = (paddr_i[1:0] == 2'b00);
    assign acc_setup   = psel_i && !penable_i;
    assign wr_en       = psel_i && penable_i && pready_q && pwrite_i && hit && !pslverr_q;
    assign pt_dir_eff  = pt_dir_q | pt_compare_en_i;

    // Address decode and read mux
    always_comb begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (idx)
            10'(PT_DATA_IDX):      rd_byte = (pt_dir_eff & pt_data_q) | (~pt_dir_eff & pt_level);
            10'(PT_PIN_INPUT_IDX): rd_byte = pt_level;
            10'(PT_DIRECTION_IDX): rd_byte = pt_dir_q;
            10'(PS_DRIVE_RED_IDX): rd_byte = {4'h0, ps_drv_q[3:0]};
            10'(PS_PULL_EN_IDX):   rd_byte = {4'h0, ps_pull_q[3:0]};
            10'(PS_DATA_IDX):      rd_byte = {4'h0, (ps_dir_q[3:0] & ps_data_q[3:0])
                                                  | (~ps_dir_q[3:0] & ps_level)};
            10'(PS_DIRECTION_IDX): rd_byte = {4'h0, ps_dir_q[3:0]};
            10'(PS_OPEN_DRAIN_IDX):rd_byte = {4'h0, ps_od_q[3:0]};
            10'(PULLUP_CTRL_IDX):  rd_byte = pullup_control_reg_q;
            10'(MODE_CTRL_IDX):    rd_byte = {5'h00, mode_q[2:0]};
            10'(PK_DATA_IDX): begin
                hit     = !pk_unmapped;
                rd_byte = (pk_dir_q & pk_data_q) | (~pk_dir_q & pk_level);
            end
            10'(PK_DIRECTION_IDX): rd_byte = pk_dir_q;
            default:               hit = 1'b0;
        endcase
        if (!aligned) begin
            hit = 1'b0;
        end
    end

    // APB slave: one wait state, answer in the second access cycle
    always_comb begin
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        echo_d    = 1'b0;
        if (psel_i && penable_i && !pready_q) begin
            pready_d  = 1'b1;
            pslverr_d = !hit;
            prdata_d  = (hit && !pwrite_i) ? {24'h000000, rd_byte} : 32'h00000000;
            echo_d    = pk_unmapped && (idx == 10'(PK_DATA_IDX));
        end else if (acc_setup) begin
            prdata_d = 32'h00000000;
        end
    end

    // Register writes take effect at the completing edge
    always_comb begin
        pt_data_d = pt_data_q;
        pt_dir_d  = pt_dir_q;
        ps_drv_d  = ps_drv_q;
        ps_pull_d = ps_pull_q;
        ps_data_d = ps_data_q;
        ps_dir_d  = ps_dir_q;
        ps_od_d   = ps_od_q;
        pullup_control_reg_d    = pullup_control_reg_q;
        mode_d    = mode_q;
        pk_data_d = pk_data_q;
        pk_dir_d  = pk_dir_q;
        if (wr_en) begin
            case (idx)
                10'(PT_DATA_IDX):       pt_data_d = pwdata_i[7:0];
                10'(PT_DIRECTION_IDX):  pt_dir_d  = pwdata_i[7:0];
                10'(PS_DRIVE_RED_IDX):  ps_drv_d  = {4'h0, pwdata_i[3:0]};
                10'(PS_PULL_EN_IDX):    ps_pull_d = {4'h0, pwdata_i[3:0]};
                10'(PS_DATA_IDX):       ps_data_d = {4'h0, pwdata_i[3:0]};
                10'(PS_DIRECTION_IDX):  ps_dir_d  = {4'h0, pwdata_i[3:0]};
                10'(PS_OPEN_DRAIN_IDX): ps_od_d   = {4'h0, pwdata_i[3:0]};
                10'(PULLUP_CTRL_IDX):   pullup_control_reg_d    = pwdata_i[7:0];
                10'(MODE_CTRL_IDX):     mode_d    = {5'h00, pwdata_i[2:0]};
                10'(PK_DATA_IDX):       pk_data_d = pwdata_i[7:0];
                10'(PK_DIRECTION_IDX):  pk_dir_d  = pwdata_i[7:0];
                default:                pt_data_d = pt_data_q;
            endcase
        end
    end

    // Chip select gap after each falling bus clock edge when not stretched
    logic       external_bus_clock_q,   external_bus_clock_d;
    logic [1:0] gap_q,    gap_d;
    always_comb begin
        external_bus_clock_d = external_bus_clock_s;
        gap_d  = (gap_q != 2'd0) ? gap_q - 2'd1 : 2'd0;
        if (external_bus_clock_q && !external_bus_clock_s && !stretch_s) begin
            gap_d = CS_GAP_CYC;
        end
    end

    // Pin drive
    logic [7:0] pt_out_d,  pt_out_q;
    logic [7:0] pt_oe_d,   pt_oe_q;
    logic [7:0] pt_cap_d,  pt_cap_q;
    logic [3:0] ps_out_d,  ps_out_q;
    logic [3:0] ps_oe_d,   ps_oe_q;
    logic [3:0] ps_rd_d,   ps_rd_q;
    logic [3:0] ps_pu_d,   ps_pu_q;
    logic [7:0] pk_out_d,  pk_out_q;
    logic [7:0] pk_oe_d,   pk_oe_q;
    logic [7:0] pk_pu_d,   pk_pu_q;
    always_comb begin
        // Port T: an enabled compare takes over the pin
        pt_oe_d  = pt_dir_eff;
        pt_out_d = (pt_compare_en_i & pt_compare_val_i) | (~pt_compare_en_i & pt_data_q);
        pt_cap_d = pt_level;
        // Port S: open drain releases the pin instead of driving high
        ps_out_d = ps_data_q[3:0] & ~ps_od_q[3:0];
        ps_oe_d  = ps_dir_q[3:0] & ~(ps_od_q[3:0] & ps_data_q[3:0]);
        ps_rd_d  = ps_drv_q[3:0] & ps_oe_d;
        ps_pu_d  = ps_pull_q[3:0] & (~ps_dir_q[3:0] | ps_od_q[3:0]);
        // Paged port as general-purpose I/O
        pk_out_d = pk_data_q;
        pk_oe_d  = pk_dir_q;
        pk_pu_d  = ~pk_dir_q & {8{pullup_control_reg_q[PULLUP_CONTROL_REG_PK_PULL_BIT]}};
        // Emulation: chip selects and page address
        if (emulate_expansion_enable) begin
            pk_oe_d  = 8'hff;
            pk_pu_d  = 8'h00;
            pk_out_d[PK_CS_EMU_BIT] = !emu_acc_s || (gap_q != 2'd0);
            pk_out_d[PK_CS_EXT_BIT] = !(ext_acc_s && !emu_acc_s)
                                      || (gap_q != 2'd0);
            pk_out_d[PK_PAGE_MSB:0] = ext_page_i;
        end
    end

    // State registers
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pt_data_q <= RST_ZERO;
            pt_dir_q  <= RST_ZERO;
            ps_drv_q  <= RST_ZERO;
            ps_pull_q <= RST_PS_PULL;
            ps_data_q <= RST_ZERO;
            ps_dir_q  <= RST_ZERO;
            ps_od_q   <= RST_ZERO;
            pullup_control_reg_q    <= RST_PULLUP_CONTROL_REG;
            mode_q    <= RST_ZERO;
            pk_data_q <= RST_ZERO;
            pk_dir_q  <= RST_ZERO;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            echo_q    <= 1'b0;
            external_bus_clock_q    <= 1'b0;
            gap_q     <= 2'd0;
            pt_out_q  <= 8'h00;
            pt_oe_q   <= 8'h00;
            pt_cap_q  <= 8'h00;
            ps_out_q  <= 4'h0;
            ps_oe_q   <= 4'h0;
            ps_rd_q   <= 4'h0;
            ps_pu_q   <= 4'hf;
            pk_out_q  <= 8'h00;
            pk_oe_q   <= 8'h00;
            pk_pu_q   <= 8'hff;
        end else begin
            pt_data_q <= pt_data_d;
            pt_dir_q  <= pt_dir_d;
            ps_drv_q  <= ps_drv_d;
            ps_pull_q <= ps_pull_d;
            ps_data_q <= ps_data_d;
            ps_dir_q  <= ps_dir_d;
            ps_od_q   <= ps_od_d;
            pullup_control_reg_q    <= pullup_control_reg_d;
            mode_q    <= mode_d;
            pk_data_q <= pk_data_d;
            pk_dir_q  <= pk_dir_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            echo_q    <= echo_d;
            external_bus_clock_q    <= external_bus_clock_d;
            gap_q     <= gap_d;
            pt_out_q  <= pt_out_d;
            pt_oe_q   <= pt_oe_d;
            pt_cap_q  <= pt_cap_d;
            ps_out_q  <= ps_out_d;
            ps_oe_q   <= ps_oe_d;
            ps_rd_q   <= ps_rd_d;
            ps_pu_q   <= ps_pu_d;
            pk_out_q  <= pk_out_d;
            pk_oe_q   <= pk_oe_d;
            pk_pu_q   <= pk_pu_d;
        end
    end

    // Outputs straight from the registers
    assign prdata_o          = prdata_q;
    assign pready_o          = pready_q;
    assign pslverr_o         = pslverr_q;
    assign pk_ext_echo_o     = echo_q;
    assign pt_pin_o          = pt_out_q;
    assign pt_pin_oe_o       = pt_oe_q;
    assign pt_capture_o      = pt_cap_q;
    assign ps_pin_o          = ps_out_q;
    assign ps_pin_oe_o       = ps_oe_q;
    assign ps_drive_reduce_o = ps_rd_q;
    assign ps_pull_on_o      = ps_pu_q;
    assign pk_pin_o          = pk_out_q;
    assign pk_pin_oe_o       = pk_oe_q;
    assign pk_pullup_on_o    = pk_pu_q;
endmodule
`default_nettype wire
